// File: verilog/rsc_map.svh
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// Host register byte addresses.
`define RSC_ADDR_UREG15 8'h3c
`define RSC_ADDR_CTRL   8'h40
`define RSC_ADDR_CFG    8'h44
`define RSC_ADDR_STAT   8'h48

// Control register: bit 0 lets the core drive the parallel bus.
`define RSC_CTRL_DRV    0
`define RSC_CTRL_RST    32'h0000_0000

// Config register: strobe bit index, strobe edge, trigger input sources.
`define RSC_CFG_STB_LSB 0
`define RSC_CFG_SLP_LSB 5
`define RSC_CFG_TS1_LSB 8
`define RSC_CFG_TS2_LSB 10
`define RSC_CFG_RST     32'h0000_0420

// Timing, with times in picoseconds.
`define RSC_CLK_PS      100000
`define RSC_WAIT_OVH    2
`define RSC_WAIT_MIN    3
`define RSC_PP_UPD_PS   20000
`define RSC_PP_GAP_CYC  ((`RSC_PP_UPD_PS + `RSC_CLK_PS - 1) / `RSC_CLK_PS)
`define RSC_SMP_PS      500
`define RSC_SMP_PER_CYC (`RSC_CLK_PS / `RSC_SMP_PS)
`define RSC_SPC_MIN     32
`define RSC_SPC_STEP    16

`endif

// File: verilog/rsc_pkg.sv
package rsc_pkg;

  // Instruction codes; all sixteen codes are legal.
  typedef enum logic [3:0] {
    OP_NOP, OP_LOAD, OP_ADD, OP_SUB, OP_SKIPZ, OP_WAIT, OP_TRIG_SET,
    OP_PP_WRITE, OP_PP_READ, OP_PP_CAPT_READ, OP_PP_TRIG_WAIT, OP_TIN_READ,
    OP_UREG_WRITE, OP_UREG_READ, OP_SPACING, OP_READOUT_START
  } rsc_op_t;

  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_TWAIT, ST_SPWAIT} rsc_fsm_t;

  // One instruction: operand is imm, or variable src when use_var is set.
  typedef struct packed {
    rsc_op_t     op;
    logic        use_var;
    logic [3:0]  dst;
    logic [3:0]  src;
    logic [31:0] imm;
  } rsc_instr_t;

  // Host register port request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rsc_bus_t;

  // Whole state of the core.
  typedef struct packed {
    rsc_fsm_t          st;
    logic              ready;
    logic              skip;
    logic [32:0]       cnt;
    logic [3:0]        gap;
    logic [31:0]       spc_smp;
    logic              tmr_start;
    logic [31:0]       tmr_smp;
    logic [15:0][31:0] vars;
    logic [15:0][31:0] ureg;
    logic [31:0]       ctrl;
    logic [31:0]       cfg;
    logic [31:0]       rdata;
    logic [31:0]       pp_s1;
    logic [31:0]       pp_s2;
    logic [31:0]       pp_s3;
    logic [31:0]       capt;
    logic [31:0]       pp_out;
    logic [31:0]       pp_oe;
    logic [1:0]        tin_s1;
    logic [1:0]        tin_s2;
    logic [1:0]        trig;
    logic              ro_start;
    logic [15:0]       ro_gen;
    logic [15:0]       ro_int;
  } rsc_core_st_t;

  // Whole state of the spacing timer.
  typedef struct packed {
    logic [32:0] rem;
    logic        busy;
  } rsc_tmr_st_t;

endpackage

// File: verilog/rsc_spacing_timer.sv
`timescale 1ns/1ps
`include "rsc_map.svh"

module rsc_spacing_timer (
  input  logic        ref_clk, // Sequencer clock.
  input  logic        rst_n,   // Synchronised reset, active low.
  input  logic        start,   // One-cycle pulse starting a spacing.
  input  logic [31:0] samples, // Requested spacing in samples.
  output logic        busy     // High while a spacing runs.
);
  import rsc_pkg::*;

  rsc_tmr_st_t s;   // Registered state.
  rsc_tmr_st_t n;   // Next state.
  logic [32:0] eff; // Spacing after rounding and floor.

  // Round up to the step and never go below the minimum.
  always_comb begin
    eff = (33'(samples) + 33'(`RSC_SPC_STEP - 1)) & ~33'(`RSC_SPC_STEP - 1);
    if (eff < 33'(`RSC_SPC_MIN)) begin
      eff = 33'(`RSC_SPC_MIN);
    end
  end

  // Each clock covers a fixed number of samples at the sample rate.
  always_comb begin
    n = s;
    if (start) begin
      n.rem = eff;
    end else if (s.rem > 33'(`RSC_SMP_PER_CYC)) begin
      n.rem = s.rem - 33'(`RSC_SMP_PER_CYC);
    end else begin
      n.rem = 33'h0_0000_0000;
    end
    n.busy = (n.rem != 33'h0_0000_0000);
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign busy = s.busy;

  AST_SPC_ROUND: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start && samples == 32'h0000_0021 |=> s.rem == 33'h0_0000_0030)
    else $error("Spacing not rounded up to the step.");
  AST_SPC_FLOOR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start && samples == 32'h0000_0000 |=> s.rem == 33'h0_0000_0020 && busy)
    else $error("Spacing below the minimum.");
  AST_SPC_RUN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start && samples == 32'h0000_0190 |=> busy ##1 busy ##1 !busy)
    else $error("Spacing length wrong.");

endmodule

// File: verilog/rsc_core.sv
`timescale 1ns/1ps
`include "rsc_map.svh"

module rsc_core (
  input  logic                ref_clk,     // Sequencer clock, 10 MHz.
  input  logic                nrst,        // Asynchronous reset, active low.
  input  rsc_pkg::rsc_bus_t   bus,         // Host register request.
  output logic [31:0]         rdata,       // Host read data, cycle after rd.
  input  logic                cmd_valid,   // Instruction offered.
  input  rsc_pkg::rsc_instr_t cmd,         // Instruction word.
  output logic                cmd_ready,   // Core takes an instruction.
  input  logic [31:0]         pp_in,       // Parallel bus pin levels.
  output logic [31:0]         pp_out,      // Parallel bus drive value.
  output logic [31:0]         pp_oe,       // Parallel bus drive enables.
  input  logic [1:0]          trig_in,     // Physical trigger pins A and B.
  output logic [1:0]          trig_out,    // Sequencer trigger outputs.
  output logic                ro_start,    // Readout launch pulse.
  output logic [15:0]         ro_gen_mask, // Waveform generators to launch.
  output logic [15:0]         ro_int_mask  // Integrators to launch.
);
  import rsc_pkg::*;

  logic [1:0]   rst_sync_ff; // Reset release synchroniser.
  logic         rst_n;       // Synchronised reset.
  rsc_core_st_t s;           // Registered state.
  rsc_core_st_t n;           // Next state.
  logic         tmr_busy;    // Spacing timer running.
  logic         acc;         // Instruction taken this edge.
  logic         run;         // Taken and not skipped.
  logic [31:0]  opnd;        // Resolved operand.
  logic         stb_ev;      // Parallel-port trigger event.
  logic         spc_blk;     // A spacing is still in flight.
  logic [4:0]   stb_idx;     // Strobe bit index.
  logic [1:0]   slope;       // Bit 0 rising, bit 1 falling.

  // Release the reset through two flops so no flop sees a ragged release.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Picks a trigger source: pin A, pin B, or one of our own outputs.
  function automatic logic tsrc(input logic [1:0] sel, input logic [1:0] pins,
                                input logic [1:0] trg);
    case (sel)
      2'h0:    tsrc = pins[0];
      2'h1:    tsrc = pins[1];
      2'h2:    tsrc = trg[0];
      default: tsrc = trg[1];
    endcase
  endfunction

  // Host register read mux; unmapped addresses read as zero.
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input rsc_core_st_t st,
                                         input logic tb);
    rd_mux = 32'h0000_0000;
    if (a <= `RSC_ADDR_UREG15 && a[1:0] == 2'h0) begin
      rd_mux = st.ureg[a[5:2]];
    end else if (a == `RSC_ADDR_CTRL) begin
      rd_mux = st.ctrl;
    end else if (a == `RSC_ADDR_CFG) begin
      rd_mux = st.cfg;
    end else if (a == `RSC_ADDR_STAT) begin
      rd_mux = {28'h000_0000, st.st != ST_IDLE, tb, st.trig};
    end
  endfunction

  // Operand comes from a variable or from the immediate.
  assign opnd = cmd.use_var ? s.vars[cmd.src] : cmd.imm;
  assign acc = cmd_valid && s.ready;
  assign run = acc && !s.skip;
  // A start pulse still in its flop counts as running; this closes the
  // one-cycle hole before the timer raises busy.
  assign spc_blk = tmr_busy || s.tmr_start;
  assign stb_idx = s.cfg[`RSC_CFG_STB_LSB +: 5];
  assign slope = s.cfg[`RSC_CFG_SLP_LSB +: 2];

  // Edge detection reads only the second and third sync stages.
  assign stb_ev = (slope[0] && s.pp_s2[stb_idx] && !s.pp_s3[stb_idx]) ||
                  (slope[1] && !s.pp_s2[stb_idx] && s.pp_s3[stb_idx]);

  // Next-state logic for the whole core.
  always_comb begin
    n = s;
    n.ro_start = 1'b0;
    n.tmr_start = 1'b0;
    n.rdata = 32'h0000_0000;
    // Pins pass two flops before any logic looks at them.
    n.pp_s1 = pp_in;
    n.pp_s2 = s.pp_s1;
    n.pp_s3 = s.pp_s2;
    n.tin_s1 = trig_in;
    n.tin_s2 = s.tin_s1;
    if (stb_ev) begin
      n.capt = s.pp_s2;
    end
    if (s.gap != 4'h0) begin
      n.gap = s.gap - 4'h1;
    end
    n.pp_oe = {32{s.ctrl[`RSC_CTRL_DRV]}};
    // Host port; read data stand only in the cycle after the strobe.
    if (bus.rd) begin
      n.rdata = rd_mux(bus.addr, s, tmr_busy);
    end
    if (bus.wr) begin
      if (bus.addr <= `RSC_ADDR_UREG15 && bus.addr[1:0] == 2'h0) begin
        n.ureg[bus.addr[5:2]] = bus.wdata;
      end else if (bus.addr == `RSC_ADDR_CTRL) begin
        n.ctrl = bus.wdata;
      end else if (bus.addr == `RSC_ADDR_CFG) begin
        n.cfg = bus.wdata;
      end
    end
    // Sequencer; a write from it lands after the host's and so wins.
    unique case (s.st)
      ST_IDLE: begin
        if (acc && s.skip) begin
          n.skip = 1'b0;
        end else if (run) begin
          unique case (cmd.op)
            OP_NOP: begin
            end
            OP_LOAD: begin
              n.vars[cmd.dst] = opnd;
            end
            OP_ADD: begin
              n.vars[cmd.dst] = s.vars[cmd.dst] + opnd;
            end
            OP_SUB: begin
              n.vars[cmd.dst] = s.vars[cmd.dst] - opnd;
            end
            OP_SKIPZ: begin
              n.skip = (opnd == 32'h0000_0000);
            end
            OP_WAIT: begin
              // Stall is max(n,1)+2 cycles; the count holds one less.
              n.cnt = (opnd == 32'h0000_0000) ? 33'(`RSC_WAIT_MIN - 1) :
                      33'(opnd) + 33'(`RSC_WAIT_OVH - 1);
              n.st = ST_WAIT;
            end
            OP_TRIG_SET: begin
              n.trig = opnd[1:0];
            end
            OP_PP_WRITE: begin
              n.pp_out = opnd;
              n.gap = 4'(`RSC_PP_GAP_CYC - 1);
            end
            OP_PP_READ: begin
              n.vars[cmd.dst] = s.pp_s2;
            end
            OP_PP_CAPT_READ: begin
              n.vars[cmd.dst] = s.capt;
            end
            OP_PP_TRIG_WAIT: begin
              n.st = ST_TWAIT;
            end
            OP_TIN_READ: begin
              // Index 2 picks the second input, anything else the first.
              n.vars[cmd.dst] = {31'h0000_0000, (cmd.imm == 32'h0000_0002) ?
                tsrc(s.cfg[`RSC_CFG_TS2_LSB +: 2], s.tin_s2, s.trig) :
                tsrc(s.cfg[`RSC_CFG_TS1_LSB +: 2], s.tin_s2, s.trig)};
            end
            OP_UREG_WRITE: begin
              n.ureg[cmd.dst] = opnd;
            end
            OP_UREG_READ: begin
              n.vars[cmd.dst] = s.ureg[cmd.src];
            end
            OP_SPACING: begin
              if (spc_blk) begin
                n.spc_smp = opnd;
                n.st = ST_SPWAIT;
              end else begin
                n.tmr_start = 1'b1;
                n.tmr_smp = opnd;
              end
            end
            OP_READOUT_START: begin
              // Does not look at the timer, so playback overlaps spacing.
              n.ro_start = 1'b1;
              n.ro_gen = cmd.imm[15:0];
              n.ro_int = cmd.imm[31:16];
            end
          endcase
        end
      end
      ST_WAIT: begin
        n.cnt = s.cnt - 33'h0_0000_0001;
        if (s.cnt == 33'h0_0000_0001) begin
          n.st = ST_IDLE;
        end
      end
      ST_TWAIT: begin
        if (stb_ev) begin
          n.st = ST_IDLE;
        end
      end
      ST_SPWAIT: begin
        if (!spc_blk) begin
          n.tmr_start = 1'b1;
          n.tmr_smp = s.spc_smp;
          n.st = ST_IDLE;
        end
      end
    endcase
    // Nothing is taken while stalled; sequencer outputs hold, while the host port still drives rdata and pp_oe.
    n.ready = (n.st == ST_IDLE) && (n.gap == 4'h0);
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= `RSC_CTRL_RST;
      s.cfg <= `RSC_CFG_RST;
    end else begin
      s <= n;
    end
  end

  // Spacing timer, running on its own beside the sequencer.
  rsc_spacing_timer u_tmr (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (s.tmr_start),
    .samples (s.tmr_smp),
    .busy    (tmr_busy)
  );

  assign rdata = s.rdata;
  assign cmd_ready = s.ready;
  assign pp_out = s.pp_out;
  assign pp_oe = s.pp_oe;
  assign trig_out = s.trig;
  assign ro_start = s.ro_start;
  assign ro_gen_mask = s.ro_gen;
  assign ro_int_mask = s.ro_int;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_WAIT_LEN: assert property (
    run && cmd.op == OP_WAIT && !cmd.use_var && cmd.imm == 32'h0000_0003
    |=> !cmd_ready [*4] ##1 cmd_ready)
    else $error("Wait of three did not stall five cycles.");
  AST_WAIT_MIN: assert property (
    run && cmd.op == OP_WAIT && !cmd.use_var && cmd.imm <= 32'h0000_0001
    |=> !cmd_ready [*2] ##1 cmd_ready)
    else $error("Short wait did not stall three cycles.");
  AST_TRIG_OUT: assert property (
    run && cmd.op == OP_TRIG_SET |=> trig_out == $past(opnd[1:0]))
    else $error("Trigger outputs differ from operand.");
  AST_PP_WRITE: assert property (
    run && cmd.op == OP_PP_WRITE |=> pp_out == $past(opnd))
    else $error("Port output differs from operand.");
  AST_CAPT: assert property (
    stb_ev |=> s.capt == $past(s.pp_s2))
    else $error("Strobe word not captured.");
  AST_TWAIT: assert property (
    s.st == ST_TWAIT && !stb_ev |=> s.st == ST_TWAIT && !cmd_ready)
    else $error("Trigger wait left without strobe.");
  AST_UREG: assert property (
    run && cmd.op == OP_UREG_WRITE |=> s.ureg[$past(cmd.dst)] == $past(opnd))
    else $error("User register not written.");
  AST_COND: assert property (
    run && cmd.op == OP_SKIPZ |=> s.skip == ($past(opnd) == 32'h0000_0000))
    else $error("Zero test wrong.");
  AST_SPC_BLOCK: assert property (
    run && cmd.op == OP_SPACING && spc_blk |=> s.st == ST_SPWAIT && !cmd_ready)
    else $error("Second spacing did not stall.");
  AST_RO_PAR: assert property (
    run && cmd.op == OP_READOUT_START |=> ro_start && cmd_ready)
    else $error("Readout start was held back.");
  AST_STALL: assert property (
    s.st != ST_IDLE |-> !cmd_ready)
    else $error("Core ready while stalled.");

endmodule

// File: verif/rsc_pp_partner.sv
`timescale 1ns/1ps

// External equipment on the parallel bus: it shows a word with the strobe bit low,
// then raises the strobe bit after a chosen number of cycles, or never if that number is zero.
module rsc_pp_partner (
  input  logic        ref_clk, // Sequencer clock.
  input  logic        nrst,    // Reset, active low; the equipment then drives all zeros.
  input  logic        send,    // One-cycle request to present a word.
  input  logic [31:0] word,    // Word to present.
  input  logic [7:0]  dly,     // Cycles from word to strobe; zero never strobes.
  input  logic [31:0] pp_out,  // Core drive value.
  input  logic [31:0] pp_oe,   // Core drive enables.
  output logic [31:0] pp_wire  // Resolved bus level.
);
  logic [31:0] drv_ff; // Level that the equipment drives.
  logic [7:0]  cnt_ff; // Countdown to the strobe, zero when idle.

  // Data is set up with the strobe low first, so the capture always sees a settled word.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      drv_ff <= 32'h0000_0000;
      cnt_ff <= 8'h00;
    end else if (send) begin
      drv_ff <= word & 32'hFFFF_FFFE;
      cnt_ff <= dly;
    end else if (cnt_ff == 8'h01) begin
      drv_ff <= drv_ff | 32'h0000_0001;
      cnt_ff <= 8'h00;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  // Each bit carries the core's value where it drives, else the equipment's.
  assign pp_wire = (pp_oe & pp_out) | (~pp_oe & drv_ff);
endmodule

// File: verif/rsc_core_test.sv
`timescale 1ns/1ps
`include "rsc_map.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end

module rsc_core_test;
  import rsc_pkg::*;
  typedef struct {rsc_op_t op; logic [31:0] imm; logic [31:0] exp; bit trg;} rsc_row_t;
  logic        ref_clk, nrst, cmd_valid, cmd_ready, ro_start, psend;
  rsc_bus_t    bus;
  rsc_instr_t  cmd;
  logic [31:0] rdata, pp_out, pp_oe, pp_wire, pword, rv;
  logic [1:0]  trig_in, trig_out;
  logic [15:0] ro_gen_mask, ro_int_mask;
  logic [7:0]  pdly;
  int          bad_count, tests_run, cyc, t0, n;
  // Ordinary instructions: variable 1, or the port-write row's own value, is shown on the bus, trigger rows on trig_out.
  rsc_row_t rows[12] = '{
    '{OP_LOAD, 32'h0000_0005, 32'h0000_0005, 0}, '{OP_ADD, 32'h0000_0007, 32'h0000_000C, 0},
    '{OP_SUB, 32'h0000_0014, 32'hFFFF_FFF8, 0}, '{OP_ADD, 32'h0000_0008, 32'h0000_0000, 0},
    '{OP_LOAD, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 0}, '{OP_PP_WRITE, 32'h8000_0001, 32'h8000_0001, 0},
    '{OP_TRIG_SET, 32'h0000_0000, 32'h0000_0000, 1}, '{OP_TRIG_SET, 32'h0000_0001, 32'h0000_0001, 1},
    '{OP_TRIG_SET, 32'h0000_0002, 32'h0000_0002, 1}, '{OP_TRIG_SET, 32'h0000_0003, 32'h0000_0003, 1},
    '{OP_TRIG_SET, 32'h0000_0006, 32'h0000_0002, 1}, '{OP_TRIG_SET, 32'hFFFF_FFFD, 32'h0000_0001, 1}};
  int          wv[4] = '{0, 1, 3, 9};
  logic [31:0] sk[4] = '{32'h0000_0000, 32'h0000_0001, 32'h8000_0000, 32'h0000_0000};
  int          sp[7][2] = '{'{0, 1}, '{32, 1}, '{33, 1}, '{193, 2}, '{200, 2},
                             '{400, 2}, '{401, 3}};

  rsc_core u_dut (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .pp_in(pp_wire), .pp_out(pp_out),
    .pp_oe(pp_oe), .trig_in(trig_in), .trig_out(trig_out), .ro_start(ro_start),
    .ro_gen_mask(ro_gen_mask), .ro_int_mask(ro_int_mask));
  rsc_pp_partner u_far (.ref_clk(ref_clk), .nrst(nrst), .send(psend), .word(pword), .dly(pdly),
    .pp_out(pp_out), .pp_oe(pp_oe), .pp_wire(pp_wire));

  // Free-running 10 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Cycle count, also used as a hang guard well above the expected run length.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      $display("BAD timeout exp %h got %h", 0, cyc);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Offers an instruction and returns just after the edge that takes it; valid stays up.
  task automatic issue(rsc_op_t o, logic [3:0] ds, logic [3:0] sr, logic uv, logic [31:0] im);
    cmd_valid <= 1'b1;
    cmd <= '{op: o, use_var: uv, dst: ds, src: sr, imm: im};
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1) @(posedge ref_clk);
  endtask

  // Drops valid and lets the effect of the last instruction land.
  task automatic cidle();
    cmd_valid <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] dt);
    bus <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
    @(posedge ref_clk);
    #1;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    v = rdata;
    @(posedge ref_clk);
    #1;
  endtask

  // Parallel equipment presents a word, strobing after dl cycles, or never when dl is zero.
  task automatic psnd(logic [31:0] w, logic [7:0] dl);
    pword <= w;
    pdly <= dl;
    psend <= 1'b1;
    @(posedge ref_clk);
    psend <= 1'b0;
    #1;
  endtask

  initial begin
    {nrst, cmd_valid, psend, trig_in, pdly} = '0;
    {bus, cmd, pword} = '0;
    {cyc, bad_count, tests_run} = '0;
    repeat (10) @(posedge ref_clk);
    `CHK("rst_outs", 68'h0, {cmd_ready, pp_out, pp_oe, trig_out, ro_start})
    nrst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    rd(`RSC_ADDR_CTRL, rv);
    `CHK("ctrl", `RSC_CTRL_RST, rv)
    rd(`RSC_ADDR_CFG, rv);
    `CHK("cfg", `RSC_CFG_RST, rv)
    rd(8'h80, rv);
    `CHK("unmapped", 32'h0000_0000, rv)
    $display("test reset done");
    foreach (rows[i]) begin
      issue(rows[i].op, 4'd1, 4'd0, 1'b0, rows[i].imm);
      if (!rows[i].trg && rows[i].op != OP_PP_WRITE) issue(OP_PP_WRITE, 4'd0, 4'd1, 1'b1, 32'h0);
      cidle();
      if (rows[i].trg) `CHK("trig_out", rows[i].exp[1:0], trig_out)
      else `CHK("pp_out", rows[i].exp, pp_out)
    end
    $display("test rows done");
    // The next instruction must be taken exactly max(n,1)+2 edges after the wait.
    foreach (wv[i]) begin
      issue(OP_WAIT, 4'd0, 4'd0, 1'b0, wv[i]);
      t0 = cyc;
      issue(OP_NOP, 4'd0, 4'd0, 1'b0, 32'h0);
      `CHK("wait_edges", (wv[i] < 2 ? 1 : wv[i]) + 2, cyc - t0)
    end
    rv = 32'h0000_0000;
    issue(OP_PP_WRITE, 4'd0, 4'd0, 1'b0, rv);
    foreach (sk[i]) begin
      issue(OP_LOAD, 4'd2, 4'd0, 1'b0, sk[i]);
      issue(OP_SKIPZ, 4'd0, 4'd2, 1'b1, 32'h0);
      issue(OP_PP_WRITE, 4'd0, 4'd0, 1'b0, sk[i] + 32'h0000_0001);
      cidle();
      if (sk[i] != 0) rv = sk[i] + 32'h0000_0001;
      `CHK("skipz", rv, pp_out)
    end
    $display("test wait_skip done");
    for (n = 0; n < 8; n++) begin
      trig_in <= n[1:0];
      repeat (4) @(posedge ref_clk);
      issue(OP_TIN_READ, 4'd7, 4'd0, 1'b0, 32'(n / 4 + 1));
      issue(OP_PP_WRITE, 4'd0, 4'd7, 1'b1, 32'h0);
      cidle();
      `CHK("tin", 32'(n[n / 4]), pp_out)
    end
    $display("test trig_in done");
    // A slow strobe holds the trigger wait; the captured word outlives the live one.
    psnd(32'h5A00_F0F0, 8'd20);
    issue(OP_PP_TRIG_WAIT, 4'd0, 4'd0, 1'b0, 32'h0);
    t0 = cyc;
    issue(OP_NOP, 4'd0, 4'd0, 1'b0, 32'h0);
    `CHK("twait", 1, (cyc - t0 >= 15) && (cyc - t0 <= 30))
    cidle();
    psnd(32'h0123_4567, 8'd30);
    repeat (4) @(posedge ref_clk);
    issue(OP_PP_CAPT_READ, 4'd3, 4'd0, 1'b0, 32'h0);
    issue(OP_PP_READ, 4'd4, 4'd0, 1'b0, 32'h0);
    issue(OP_PP_WRITE, 4'd0, 4'd3, 1'b1, 32'h0);
    cidle();
    `CHK("capt", 32'h5A00_F0F1, pp_out)
    issue(OP_PP_WRITE, 4'd0, 4'd4, 1'b1, 32'h0);
    cidle();
    `CHK("live", 32'h0123_4566, pp_out)
    wr(`RSC_ADDR_CTRL, 32'h0000_0001);
    issue(OP_PP_WRITE, 4'd0, 4'd0, 1'b0, 32'hC3C3_3C3C);
    cidle();
    repeat (3) @(posedge ref_clk);
    `CHK("pp_oe", 32'hFFFF_FFFF, pp_oe)
    issue(OP_PP_READ, 4'd4, 4'd0, 1'b0, 32'h0);
    issue(OP_UREG_WRITE, 4'd5, 4'd4, 1'b1, 32'h0);
    cidle();
    rd(8'h14, rv);
    `CHK("ureg5", 32'hC3C3_3C3C, rv)
    wr(`RSC_ADDR_UREG15, 32'h1234_5678);
    issue(OP_UREG_READ, 4'd6, 4'd15, 1'b0, 32'h0);
    issue(OP_PP_WRITE, 4'd0, 4'd6, 1'b1, 32'h0);
    cidle();
    `CHK("ureg15", 32'h1234_5678, pp_out)
    // Back-to-back port writes are taken on consecutive edges, so the first stands on the bus for one cycle.
    issue(OP_PP_WRITE, 4'd0, 4'd0, 1'b0, 32'h0000_AAAA);
    t0 = cyc;
    #1;
    `CHK("pp_first", 32'h0000_AAAA, pp_out)
    issue(OP_PP_WRITE, 4'd0, 4'd0, 1'b0, 32'h0000_5555);
    `CHK("pp_gap", 1, cyc - t0)
    cidle();
    `CHK("pp_second", 32'h0000_5555, pp_out)
    // Trigger inputs routed from our own outputs, strobe on the falling edge.
    wr(`RSC_ADDR_CFG, 32'h0000_0E40);
    issue(OP_TRIG_SET, 4'd0, 4'd0, 1'b0, 32'h0000_0002);
    issue(OP_TIN_READ, 4'd7, 4'd0, 1'b0, 32'h0000_0002);
    issue(OP_PP_WRITE, 4'd0, 4'd7, 1'b1, 32'h0);
    cidle();
    `CHK("tin_src", 32'h0000_0001, pp_out)
    // Releasing the bus drops the strobe bit from our high drive to the equipment's low.
    psnd(32'h0F0F_00F0, 8'd0);
    issue(OP_PP_TRIG_WAIT, 4'd0, 4'd0, 1'b0, 32'h0);
    wr(`RSC_ADDR_CTRL, 32'h0000_0000);
    issue(OP_PP_CAPT_READ, 4'd3, 4'd0, 1'b0, 32'h0);
    issue(OP_PP_WRITE, 4'd0, 4'd3, 1'b1, 32'h0);
    cidle();
    `CHK("capt_fall", 32'h0F0F_00F0, pp_out)
    $display("test parallel done");
    // Readout start runs beside a spacing; a second spacing waits for the first.
    issue(OP_SPACING, 4'd0, 4'd0, 1'b0, 32'd2000);
    t0 = cyc;
    issue(OP_READOUT_START, 4'd0, 4'd0, 1'b0, 32'h0003_0005);
    `CHK("ro_overlap", 1, cyc - t0)
    // The launch pulse stands only in the cycle after the taking edge.
    #1;
    `CHK("ro_start", 1'b1, ro_start)
    `CHK("ro_masks", 32'h0003_0005, {ro_int_mask, ro_gen_mask})
    cidle();
    `CHK("ro_pulse", 1'b0, ro_start)
    // The second spacing is taken at once; the instruction after it waits.
    issue(OP_SPACING, 4'd0, 4'd0, 1'b0, 32'd32);
    issue(OP_NOP, 4'd0, 4'd0, 1'b0, 32'h0);
    `CHK("spc_block", 1, cyc - t0 >= 10)
    cidle();
    repeat (20) @(posedge ref_clk);
    #1;
    foreach (sp[i]) begin
      issue(OP_SPACING, 4'd0, 4'd0, 1'b0, sp[i][0]);
      cidle();
      bus <= '{addr: `RSC_ADDR_STAT, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      n = 0;
      repeat (30) begin
        @(posedge ref_clk);
        #1;
        if (rdata[2] === 1'b1) n++;
      end
      bus <= '0;
      @(posedge ref_clk);
      #1;
      `CHK("spc_cycles", sp[i][1], n)
    end
    $display("test spacing done");
    // A reset in mid-run clears the outputs and the config written above.
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("mid_rst_outs", 68'h0, {cmd_ready, pp_out, pp_oe, trig_out, ro_start})
    nrst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    rd(`RSC_ADDR_CFG, rv);
    `CHK("mid_rst_cfg", `RSC_CFG_RST, rv)
    $display("test mid_reset done");
    stop_test();
  end
endmodule
